// File: hdl/gp_timer.sv
/*
 * General-purpose timer with halves A and B behind an Avalon-MM slave.
 * Assumes capture pins are asynchronous and an outer decoder selects the instance.
 */
// Chosen here: register access over Avalon-MM.
// Functional notes
// - Config code 0 gives 32-bit timer, 1 RTC counter, 4 two 16-bit timers.
// - Mode field 1 is one-shot, 2 is periodic, in 32- and 16-bit setups.
// - One-shot stops after time-out; periodic keeps counting on its own.
// - Raw flags stay set until software writes one to the clear register.
// - An event interrupts only when its mask bit is set.
// - RTC count equal to match value reloads zero and keeps counting up.
// - The RTC counter runs on after a match without any clear.
// - Mode 3 is capture: edge-count when capture bit 0, edge-time when 1.
// - Edge-count stops after its edges; restart needs enable cleared then set.
// - Edge-time copies the counter into the value register at each edge.
// - Edge-time keeps running; interval load writes act next cycle.
// - PWM needs alternate bit 1, capture bit 0 and mode field 2.
// - PWM runs continuously; interval load writes change the period next cycle.
// - 16-bit timer and PWM halves use the prescaler; PWM also uses prescale match.
// - Half A load, match and value read 0xFFFF in 16-bit, all ones in 32-bit.
// - Each instance decodes the same offsets relative to its own base.
// - At zero a 16-bit timer reloads next cycle; one-shot clears its enable.
// - With trigger enabled, zero gives a one-cycle trigger pulse.
// - Edge-count decrements per edge to the match, flags, reloads, disables.
// - PWM sets at start value, clears at match value; a level bit inverts.
`include "gp_timer_cfg.svh"
module gp_timer (
	input wire logic mclk,
	input wire logic resetn,
	input wire gp_timer_pkg::avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] capture_compare_pin,
	output logic [1:0] pwm_out,
	output logic [1:0] trigger_out,
	output logic irq
);
	gp_timer_pkg::state_t q;
	gp_timer_pkg::state_t d;
	gp_timer_pkg::half_fn_t fn_a;
	gp_timer_pkg::half_fn_t fn_b;
	gp_timer_pkg::half_res_t ra;
	gp_timer_pkg::half_res_t rb;
	logic req;
	logic wr;
	logic is16;
	logic [1:0] chg;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] sel;
	logic [31:0] wd;
	logic [10:0] clr;

	function automatic gp_timer_pkg::half_fn_t fn_of(input logic [3:0] m);
		gp_timer_pkg::half_fn_t f;
		f = gp_timer_pkg::FN_IDLE;
		if (!m[`MR_AMS] && (m[1:0] == `MODE_ONE || m[1:0] == `MODE_PER)) begin
			f = gp_timer_pkg::FN_TIMER;
		end else if (!m[`MR_AMS] && m[1:0] == `MODE_CAP) begin
			f = m[`MR_CMR] ? gp_timer_pkg::FN_TIME : gp_timer_pkg::FN_COUNT;
		end else if (m[`MR_AMS] && !m[`MR_CMR] && m[1:0] == `MODE_PER) begin
			f = gp_timer_pkg::FN_PWM;
		end
		return f;
	endfunction : fn_of

	function automatic logic pick(input logic [1:0] evt, input logic r, input logic f);
		return (evt == `EVT_RISE && r) || (evt == `EVT_FALL && f) || (evt == `EVT_BOTH && (r || f));
	endfunction : pick

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = w[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Advances one 16-bit half by one clock.
	function automatic gp_timer_pkg::half_res_t step(input gp_timer_pkg::half_fn_t fn,
		input logic [15:0] cnt, input gp_timer_pkg::half_t h, input logic en,
		input logic [1:0] mr, input logic [15:0] ilr, input logic [15:0] mat,
		input logic [7:0] ps, input logic [7:0] pm, input logic edg);
		gp_timer_pkg::half_res_t r;
		logic zero;
		r = '{cnt: cnt, h: h, en: en, tmo: 1'b0, cm: 1'b0, ce: 1'b0};
		zero = (cnt == 16'h0000) && (h.pre == 8'h00);
		if (!en) begin
			r.cnt = ilr;
			r.h.pre = ps;
		end else begin
			unique case (fn)
				gp_timer_pkg::FN_TIMER, gp_timer_pkg::FN_PWM: begin
					if (fn == gp_timer_pkg::FN_PWM) begin
						if ({cnt, h.pre} == {ilr, ps}) begin
							r.h.pwm = 1'b1;
						end else if ({cnt, h.pre} == {mat, pm}) begin
							r.h.pwm = 1'b0;
						end
					end
					if (zero) begin
						r.cnt = ilr;
						r.h.pre = ps;
						if (fn == gp_timer_pkg::FN_TIMER) begin
							r.tmo = 1'b1;
							r.en = (mr != `MODE_ONE);
						end
					end else if (h.pre == 8'h00) begin
						r.h.pre = ps;
						r.cnt = cnt - 16'h0001;
					end else begin
						r.h.pre = h.pre - 8'h01;
					end
				end
				gp_timer_pkg::FN_COUNT: begin
					if (edg) begin
						r.cnt = cnt - 16'h0001;
						if (r.cnt == mat) begin
							r.cm = 1'b1;
							r.cnt = ilr;
							r.en = 1'b0;
						end
					end
				end
				gp_timer_pkg::FN_TIME: begin
					if (edg) begin
						r.h.cap = cnt;
						r.ce = 1'b1;
					end
					r.cnt = (cnt == 16'h0000) ? ilr : cnt - 16'h0001;
				end
				gp_timer_pkg::FN_IDLE: begin
				end
			endcase
		end
		return r;
	endfunction : step

	assign req = avs_req.read || avs_req.write;
	assign wr = avs_req.write && q.ack;
	assign is16 = q.cfg[`CFG_16_BIT];
	assign fn_a = fn_of(q.mode_a);
	assign fn_b = fn_of(q.mode_b);
	assign chg = ~(q.f2 ^ q.f3) & (q.f3 ^ q.lvl);
	assign rise = chg & q.f3;
	assign fall = chg & ~q.f3;
	assign sel[0] = pick(q.ctl[`CTL_A_EVT +: 2], rise[0], fall[0]);
	assign sel[1] = pick(q.ctl[`CTL_B_EVT +: 2], rise[1], fall[1]);
	assign wd = avs_req.writedata;
	assign clr = (wr && avs_req.address == `OFF_ICR) ? 11'(merge(32'h0, wd, avs_req.byteenable))
		& `IRQ_MASK : 11'h000;
	assign ra = step(fn_a, q.cnt_a[15:0], q.ha, q.ctl[`CTL_A_EN], q.mode_a[1:0],
		q.ilr_a[15:0], q.mat_a[15:0], q.ps_a, q.pm_a, sel[0]);
	assign rb = step(fn_b, q.cnt_b, q.hb, q.ctl[`CTL_B_EN], q.mode_b[1:0],
		q.ilr_b, q.mat_b, q.ps_b, q.pm_b, sel[1]);
	assign avs_waitrequest = req && !q.ack;
	assign avs_readdata = q.rdata;
	assign pwm_out = q.pout;
	assign trigger_out = q.trig;
	assign irq = q.irq;

	always_comb begin
		logic [10:0] set;
		logic [31:0] m;
		set = 11'h000;
		m = 32'h0000_0000;
		d = q;
		d.f1 = capture_compare_pin;
		d.f2 = q.f1;
		d.f3 = q.f2;
		d.lvl = q.lvl ^ chg;
		d.ack = req && !q.ack;
		d.trig = 2'b00;
		if (req && !q.ack) begin
			unique case (avs_req.address)
				`OFF_CFG: d.rdata = 32'(q.cfg);
				`OFF_MODE_A: d.rdata = 32'(q.mode_a);
				`OFF_MODE_B: d.rdata = 32'(q.mode_b);
				`OFF_CTL: d.rdata = 32'(q.ctl);
				`OFF_IMR: d.rdata = 32'(q.imr);
				`OFF_RIS: d.rdata = 32'(q.ris);
				`OFF_MIS: d.rdata = 32'(q.ris & q.imr);
				`OFF_ILR_A: d.rdata = is16 ? 32'(q.ilr_a[15:0]) : q.ilr_a;
				`OFF_ILR_B: d.rdata = 32'(q.ilr_b);
				`OFF_MAT_A: d.rdata = is16 ? 32'(q.mat_a[15:0]) : q.mat_a;
				`OFF_MAT_B: d.rdata = 32'(q.mat_b);
				`OFF_PS_A: d.rdata = 32'(q.ps_a);
				`OFF_PS_B: d.rdata = 32'(q.ps_b);
				`OFF_PM_A: d.rdata = 32'(q.pm_a);
				`OFF_PM_B: d.rdata = 32'(q.pm_b);
				`OFF_VAL_A: d.rdata = !is16 ? q.cnt_a : (fn_a == gp_timer_pkg::FN_TIME)
					? 32'(q.ha.cap) : 32'(q.cnt_a[15:0]);
				`OFF_VAL_B: d.rdata = (fn_b == gp_timer_pkg::FN_TIME) ? 32'(q.hb.cap)
					: 32'(q.cnt_b);
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		// Counting runs first; software writes of the same cycle override it, except that a flag set beats a same-cycle clear.
		if (is16) begin
			d.cnt_a = 32'(ra.cnt);
			d.ha = ra.h;
			d.ctl[`CTL_A_EN] = ra.en;
			set[`IRQ_A_TO] = ra.tmo;
			set[`IRQ_A_CM] = ra.cm;
			set[`IRQ_A_CE] = ra.ce;
			d.trig[0] = ra.tmo && q.ctl[`CTL_A_OTE];
		end else if (q.cfg == `CFG_T32) begin
			if (!q.ctl[`CTL_A_EN]) begin
				d.cnt_a = q.ilr_a;
			end else if (q.mode_a[1:0] == `MODE_ONE || q.mode_a[1:0] == `MODE_PER) begin
				if (q.cnt_a == 32'h0000_0000) begin
					d.cnt_a = q.ilr_a;
					set[`IRQ_A_TO] = 1'b1;
					d.trig[0] = q.ctl[`CTL_A_OTE];
					d.ctl[`CTL_A_EN] = (q.mode_a[1:0] != `MODE_ONE);
				end else begin
					d.cnt_a = q.cnt_a - 32'h0000_0001;
				end
			end
		end else if (q.cfg == `CFG_RTC && q.ctl[`CTL_A_EN] && rise[0]) begin
			if (q.cnt_a == q.mat_a) begin
				d.cnt_a = 32'h0000_0000;
				set[`IRQ_RTC] = 1'b1;
			end else begin
				d.cnt_a = q.cnt_a + 32'h0000_0001;
			end
		end
		if (is16) begin
			d.cnt_b = rb.cnt;
			d.hb = rb.h;
			d.ctl[`CTL_B_EN] = rb.en;
			set[`IRQ_B_TO] = rb.tmo;
			set[`IRQ_B_CM] = rb.cm;
			set[`IRQ_B_CE] = rb.ce;
			d.trig[1] = rb.tmo && q.ctl[`CTL_B_OTE];
		end
		if (wr) begin
			unique case (avs_req.address)
				`OFF_CFG: d.cfg = 3'(merge(32'(q.cfg), wd, avs_req.byteenable));
				`OFF_MODE_A: d.mode_a = 4'(merge(32'(q.mode_a), wd, avs_req.byteenable));
				`OFF_MODE_B: d.mode_b = 4'(merge(32'(q.mode_b), wd, avs_req.byteenable));
				`OFF_CTL: d.ctl = 15'(merge(32'(q.ctl), wd, avs_req.byteenable)) & `CTL_MASK;
				`OFF_IMR: d.imr = 11'(merge(32'(q.imr), wd, avs_req.byteenable)) & `IRQ_MASK;
				`OFF_ILR_A: begin
					m = merge(q.ilr_a, wd, avs_req.byteenable);
					d.ilr_a = m;
					d.cnt_a = is16 ? 32'(m[15:0]) : m;
				end
				`OFF_ILR_B: begin
					m = merge(32'(q.ilr_b), wd, avs_req.byteenable);
					d.ilr_b = m[15:0];
					d.cnt_b = m[15:0];
				end
				`OFF_MAT_A: d.mat_a = merge(q.mat_a, wd, avs_req.byteenable);
				`OFF_MAT_B: d.mat_b = 16'(merge(32'(q.mat_b), wd, avs_req.byteenable));
				`OFF_PS_A: d.ps_a = 8'(merge(32'(q.ps_a), wd, avs_req.byteenable));
				`OFF_PS_B: d.ps_b = 8'(merge(32'(q.ps_b), wd, avs_req.byteenable));
				`OFF_PM_A: d.pm_a = 8'(merge(32'(q.pm_a), wd, avs_req.byteenable));
				`OFF_PM_B: d.pm_b = 8'(merge(32'(q.pm_b), wd, avs_req.byteenable));
				default: begin
				end
			endcase
		end
		d.ris = (q.ris & ~clr) | set;
		d.pout[0] = d.ha.pwm ^ d.ctl[`CTL_A_PWML];
		d.pout[1] = d.hb.pwm ^ d.ctl[`CTL_B_PWML];
		d.irq = |(d.ris & d.imr);
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			q <= '0;
			q.ilr_a <= `RST_32;
			q.mat_a <= `RST_32;
			q.cnt_a <= `RST_32;
			q.ilr_b <= `RST_16;
			q.mat_b <= `RST_16;
			q.cnt_b <= `RST_16;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_a_zero;
		is16 && fn_a == gp_timer_pkg::FN_TIMER && q.ctl[`CTL_A_EN] && q.cnt_a[15:0] == 16'h0000
			&& q.ha.pre == 8'h00 && !(wr && avs_req.address == `OFF_ILR_A);
	endsequence
	sequence s_a_cmatch;
		is16 && fn_a == gp_timer_pkg::FN_COUNT && q.ctl[`CTL_A_EN] && sel[0]
			&& 16'(q.cnt_a[15:0] - 16'h0001) == q.mat_a[15:0];
	endsequence

	AST_RELOAD: assert property (s_a_zero |=> q.cnt_a[15:0] == $past(q.ilr_a[15:0])
		&& q.ris[`IRQ_A_TO]) else $error("Half A did not reload at zero.");
	AST_ONESHOT: assert property (s_a_zero and q.mode_a[1:0] == `MODE_ONE
		|=> !q.ctl[`CTL_A_EN]) else $error("One-shot half A kept running.");
	AST_PERIODIC: assert property (s_a_zero and q.mode_a[1:0] == `MODE_PER && !wr
		|=> q.ctl[`CTL_A_EN] [*2]) else $error("Periodic half A stopped.");
	AST_TRIG: assert property (s_a_zero and q.ctl[`CTL_A_OTE]
		|=> trigger_out[0]) else $error("No trigger pulse at zero.");
	AST_W1C: assert property (q.ris[`IRQ_A_TO] && !clr[`IRQ_A_TO]
		|=> q.ris[`IRQ_A_TO]) else $error("Raw flag dropped without a clear.");
	AST_MIS: assert property (irq == |(q.ris & q.imr))
		else $error("Interrupt differs from masked status.");
	AST_MASK: assert property (q.imr == 11'h000 && $past(q.imr) == 11'h000 |-> !irq)
		else $error("Interrupt raised with all masks clear.");
	AST_RTC: assert property (q.cfg == `CFG_RTC && q.ctl[`CTL_A_EN] && rise[0]
		&& q.cnt_a == q.mat_a && !wr |=> q.cnt_a == 32'h0 && q.ris[`IRQ_RTC] && q.ctl[`CTL_A_EN])
		else $error("RTC match did not wrap to zero.");
	AST_COUNT: assert property (s_a_cmatch and !wr |=> !q.ctl[`CTL_A_EN]
		&& q.ris[`IRQ_A_CM] && q.cnt_a[15:0] == q.ilr_a[15:0]) else $error("Edge count end wrong.");
	AST_CAPT: assert property (is16 && fn_a == gp_timer_pkg::FN_TIME && q.ctl[`CTL_A_EN]
		&& sel[0] |=> q.ha.cap == $past(q.cnt_a[15:0]) && q.ris[`IRQ_A_CE])
		else $error("Edge time capture wrong.");
	AST_RST: assert property ($rose(resetn) |-> q.ilr_a == `RST_32 && q.cnt_b == `RST_16)
		else $error("Reset values wrong.");

	sequence s_b_zero;
		is16 && fn_b == gp_timer_pkg::FN_TIMER && q.ctl[`CTL_B_EN] && q.cnt_b == 16'h0000
			&& q.hb.pre == 8'h00 && !(wr && avs_req.address == `OFF_ILR_B);
	endsequence

	AST_B_RELOAD: assert property (s_b_zero |=> q.cnt_b == $past(q.ilr_b)
		&& q.ris[`IRQ_B_TO]) else $error("Half B did not reload at zero.");
	AST_B_PERIODIC: assert property (s_b_zero and q.mode_b[1:0] == `MODE_PER && !wr
		|=> q.ctl[`CTL_B_EN]) else $error("Periodic half B stopped.");
	AST_B_TRIG: assert property (s_b_zero and q.ctl[`CTL_B_OTE]
		|=> trigger_out[1]) else $error("No trigger pulse at zero on half B.");
	AST_PWM_SET: assert property (is16 && fn_b == gp_timer_pkg::FN_PWM && q.ctl[`CTL_B_EN]
		&& {q.cnt_b, q.hb.pre} == {q.ilr_b, q.ps_b} && !wr |=> pwm_out[1] != q.ctl[`CTL_B_PWML])
		else $error("PWM output not set at start value.");
	AST_PWM_CLR: assert property (is16 && fn_b == gp_timer_pkg::FN_PWM && q.ctl[`CTL_B_EN]
		&& {q.cnt_b, q.hb.pre} == {q.mat_b, q.pm_b} && {q.cnt_b, q.hb.pre} != {q.ilr_b, q.ps_b}
		&& !wr |=> pwm_out[1] == q.ctl[`CTL_B_PWML]) else $error("PWM output not cleared at match.");
endmodule : gp_timer

// File: hdl/gp_timer_cfg.svh
/*
 * Offsets, field positions, codes and reset values of the timer block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef GP_TIMER_CFG_SVH
`define GP_TIMER_CFG_SVH
`define OFF_CFG 12'h000
`define OFF_MODE_A 12'h004
`define OFF_MODE_B 12'h008
`define OFF_CTL 12'h00C
`define OFF_IMR 12'h018
`define OFF_RIS 12'h01C
`define OFF_MIS 12'h020
`define OFF_ICR 12'h024
`define OFF_ILR_A 12'h028
`define OFF_ILR_B 12'h02C
`define OFF_MAT_A 12'h030
`define OFF_MAT_B 12'h034
`define OFF_PS_A 12'h038
`define OFF_PS_B 12'h03C
`define OFF_PM_A 12'h040
`define OFF_PM_B 12'h044
`define OFF_VAL_A 12'h048
`define OFF_VAL_B 12'h04C
`define CTL_A_EN 0
`define CTL_A_EVT 2
`define CTL_RTC_EN 4
`define CTL_A_OTE 5
`define CTL_A_PWML 6
`define CTL_B_EN 8
`define CTL_B_EVT 10
`define CTL_B_OTE 13
`define CTL_B_PWML 14
`define CTL_MASK 15'h6F7F
`define IRQ_A_TO 0
`define IRQ_A_CM 1
`define IRQ_A_CE 2
`define IRQ_RTC 3
`define IRQ_B_TO 8
`define IRQ_B_CM 9
`define IRQ_B_CE 10
`define IRQ_MASK 11'h70F
`define CFG_T32 3'h0
`define CFG_RTC 3'h1
`define CFG_16_BIT 2
`define MR_AMS 3
`define MR_CMR 2
`define MODE_ONE 2'h1
`define MODE_PER 2'h2
`define MODE_CAP 2'h3
`define EVT_RISE 2'h0
`define EVT_FALL 2'h1
`define EVT_BOTH 2'h3
`define RST_32 32'hFFFFFFFF
`define RST_16 16'hFFFF
`endif

// File: hdl/gp_timer_pkg.sv
/*
 * Types of the timer block: bus carrier, half function and state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gp_timer_pkg;
	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avs_req_t;
	typedef enum logic [2:0] {FN_IDLE, FN_TIMER, FN_COUNT, FN_TIME, FN_PWM} half_fn_t;
	typedef struct packed {
		logic [7:0] pre;
		logic [15:0] cap;
		logic pwm;
	} half_t;
	typedef struct packed {
		logic [15:0] cnt;
		half_t h;
		logic en;
		logic tmo;
		logic cm;
		logic ce;
	} half_res_t;
	typedef struct packed {
		logic [2:0] cfg;
		logic [3:0] mode_a;
		logic [3:0] mode_b;
		logic [14:0] ctl;
		logic [10:0] imr;
		logic [10:0] ris;
		logic [31:0] ilr_a;
		logic [15:0] ilr_b;
		logic [31:0] mat_a;
		logic [15:0] mat_b;
		logic [7:0] ps_a;
		logic [7:0] ps_b;
		logic [7:0] pm_a;
		logic [7:0] pm_b;
		logic [31:0] cnt_a;
		logic [15:0] cnt_b;
		half_t ha;
		half_t hb;
		logic [1:0] f1;
		logic [1:0] f2;
		logic [1:0] f3;
		logic [1:0] lvl;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] trig;
		logic [1:0] pout;
		logic irq;
	} state_t;
endpackage : gp_timer_pkg

// File: dv/capture_src.sv
/*
 * Capture pin source: trains of pulses, or a slow clock, on one pin.
 * Assumes go is held for one cycle by the bench and half is at least 3.
 */
module capture_src (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic go,
	input wire logic go_pin,
	input wire logic [15:0] n_pulse,
	input wire logic [15:0] half,
	output logic [1:0] pin,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [16:0] left_q;
	logic [15:0] tick_q;
	logic sel_q;
	assign busy = (left_q != 17'h0);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin <= 2'h0;
			left_q <= 17'h0;
			tick_q <= 16'h0;
			sel_q <= 1'b0;
		end else if (go && !busy) begin
			sel_q <= go_pin;
			left_q <= {n_pulse, 1'b0};
			tick_q <= half;
		end else if (busy) begin
			if (tick_q == 16'h1) begin
				pin[sel_q] <= ~pin[sel_q]; // Toggle at the set half period.
				left_q <= left_q - 17'h1;
				tick_q <= half;
			end else begin
				tick_q <= tick_q - 16'h1;
			end
		end
	end
endmodule : capture_src

// File: dv/general_purpose_timer_module_tb.sv
/*
 * Self-checking bench of the timer: bus tasks and one scenario per mode.
 * Assumes the design files and the capture source model are compiled first.
 */
`include "gp_timer_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module general_purpose_timer_module_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RTC_HALF = 3052;
	localparam int LIMIT = 60000;
	logic mclk;
	logic resetn;
	gp_timer_pkg::avs_req_t req;
	logic [31:0] rdata;
	logic wreq;
	logic [1:0] pin;
	logic [1:0] pwm;
	logic [1:0] trig;
	logic irq;
	logic go;
	logic go_pin;
	logic [15:0] n_pulse;
	logic [15:0] half;
	logic busy;
	logic [31:0] got;
	logic [31:0] v;
	logic pt;
	int miscompares;
	int n_tests;
	int cyc;
	int tp;
	int dbl;
	int hi;
	int hi2;
	gp_timer u_dut (.mclk(mclk), .resetn(resetn), .avs_req(req), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .capture_compare_pin(pin), .pwm_out(pwm),
		.trigger_out(trig), .irq(irq));
	capture_src u_src (.mclk(mclk), .resetn(resetn), .go(go), .go_pin(go_pin),
		.n_pulse(n_pulse), .half(half), .pin(pin), .busy(busy));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	always @(posedge mclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			miscompares++;
			test_done;
		end
	end
	task automatic acc(input logic rw, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{read: !rw, write: rw, address: a, writedata: d, byteenable: 4'hF};
		do @(posedge mclk); while (wreq !== 1'b0);
		got = rdata;
		req <= '0;
	endtask : acc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		acc(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulses(input logic p, input logic [15:0] n, input logic [15:0] h);
		@(posedge mclk);
		go <= 1'b1;
		go_pin <= p;
		n_pulse <= n;
		half <= h;
		@(posedge mclk);
		go <= 1'b0;
		do @(posedge mclk); while (busy === 1'b1);
		repeat (8) @(posedge mclk);
	endtask : pulses
	task automatic count_hi(output int h);
		h = 0;
		repeat (210) begin
			@(posedge mclk);
			if (pwm[1] === 1'b1) h++;
		end
	endtask : count_hi
	initial begin
		req = '0;
		go = 1'b0;
		go_pin = 1'b0;
		n_pulse = 16'h0;
		half = 16'h3;
		resetn = 1'b0;
		miscompares = 0;
		n_tests = 0;
		cyc = 0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		rd(`OFF_ILR_A);
		`CHK("ilr_a32", 32'hFFFFFFFF, got)
		rd(`OFF_MAT_B);
		`CHK("mat_b", 32'h0000FFFF, got)
		rd(12'h050);
		`CHK("unmapped", 32'h0, got)
		wr(`OFF_CFG, 32'h4);
		rd(`OFF_MAT_A);
		`CHK("mat_a16", 32'h0000FFFF, got)
		wr(`OFF_CFG, 32'h0);
		wr(`OFF_MODE_A, 32'h1);
		wr(`OFF_ILR_A, 32'd40);
		wr(`OFF_IMR, 32'h1);
		wr(`OFF_CTL, 32'h1);
		repeat (60) @(posedge mclk);
		`CHK("irq_on", 1'b1, irq)
		rd(`OFF_MIS);
		`CHK("mis", 32'h1, got)
		wr(`OFF_IMR, 32'h0);
		repeat (3) @(posedge mclk);
		`CHK("irq_masked", 1'b0, irq)
		rd(`OFF_RIS);
		`CHK("ris_held", 32'h1, got)
		wr(`OFF_ICR, 32'h1);
		repeat (60) @(posedge mclk);
		rd(`OFF_RIS);
		`CHK("oneshot_stop", 32'h0, got)
		wr(`OFF_CFG, 32'h4);
		wr(`OFF_MODE_B, 32'h2);
		wr(`OFF_ILR_B, 32'd10);
		wr(`OFF_CTL, 32'h2121);
		tp = 0;
		dbl = 0;
		pt = 1'b0;
		repeat (100) begin
			@(posedge mclk);
			if (trig[1] === 1'b1) tp++;
			if (trig[1] === 1'b1 && pt === 1'b1) dbl++;
			pt = trig[1];
		end
		`CHK("trig_width", 0, dbl)
		`CHK("trig_count", 1'b1, tp >= 8)
		wr(`OFF_ICR, 32'h101);
		repeat (30) @(posedge mclk);
		rd(`OFF_RIS);
		`CHK("periodic", 32'h100, got)
		wr(`OFF_CTL, 32'h0);
		wr(`OFF_ICR, 32'h707);
		wr(`OFF_MODE_A, 32'h3);
		wr(`OFF_ILR_A, 32'd10);
		wr(`OFF_MAT_A, 32'd6);
		wr(`OFF_CTL, 32'hC);
		wr(`OFF_CTL, 32'hD);
		pulses(1'b0, 16'd1, 16'd5);
		rd(`OFF_RIS);
		`CHK("cnt_two_edges", 32'h0, got)
		pulses(1'b0, 16'd1, 16'd5);
		rd(`OFF_RIS);
		`CHK("cnt_match", 32'h2, got)
		rd(`OFF_CTL);
		`CHK("cnt_en_off", 1'b0, got[0])
		wr(`OFF_ICR, 32'h2);
		pulses(1'b0, 16'd3, 16'd5);
		rd(`OFF_RIS);
		`CHK("cnt_ignored", 32'h0, got)
		wr(`OFF_CTL, 32'h0);
		wr(`OFF_MODE_A, 32'h7);
		wr(`OFF_ILR_A, 32'h0000FFFF);
		wr(`OFF_CTL, 32'h1);
		pulses(1'b0, 16'd1, 16'd5);
		rd(`OFF_RIS);
		`CHK("time_flag", 32'h4, got)
		rd(`OFF_VAL_A);
		v = got;
		`CHK("time_cap", 1'b1, v < 32'h0000FFFF)
		pulses(1'b0, 16'd1, 16'd5);
		rd(`OFF_VAL_A);
		`CHK("time_runs", 1'b1, got < v)
		wr(`OFF_CTL, 32'h0);
		wr(`OFF_MODE_B, 32'hA);
		wr(`OFF_ILR_B, 32'd20);
		wr(`OFF_MAT_B, 32'd5);
		wr(`OFF_CTL, 32'h100);
		count_hi(hi);
		`CHK("pwm_toggles", 1'b1, hi > 0 && hi < 210)
		wr(`OFF_CTL, 32'h0);
		wr(`OFF_CTL, 32'h4100);
		count_hi(hi2);
		`CHK("pwm_invert", 1'b1, hi > hi2)
		wr(`OFF_CTL, 32'h0);
		wr(`OFF_ICR, 32'h70F);
		wr(`OFF_CFG, 32'h1);
		wr(`OFF_ILR_A, 32'h0);
		wr(`OFF_MAT_A, 32'd3);
		wr(`OFF_IMR, 32'h8);
		wr(`OFF_CTL, 32'h1);
		pulses(1'b0, 16'd4, RTC_HALF[15:0]);
		rd(`OFF_RIS);
		`CHK("rtc_flag", 32'h8, got)
		rd(`OFF_VAL_A);
		v = got;
		`CHK("rtc_wrap", 1'b1, v < 32'd4)
		pulses(1'b0, 16'd1, RTC_HALF[15:0]);
		rd(`OFF_VAL_A);
		`CHK("rtc_runs", 1'b1, got != v)
		`CHK("rtc_irq", 1'b1, irq)
		test_done;
	end
endmodule : general_purpose_timer_module_tb
